/* File: src/cdv_pkg.sv */
// Package: constants for the synchronous divide-by-2/4/8 clock divider
package cdv_pkg;
	// ------------------------------------------------------------
	// Divider layout
	// ------------------------------------------------------------
	localparam int CDV_STAGES = 3;
	localparam logic [CDV_STAGES-1:0] CDV_COUNT_RESET = 3'h0;
	localparam logic [CDV_STAGES-1:0] CDV_COUNT_STEP = 3'h1;
	localparam int CDV_HALF_BIT = 0;
	localparam int CDV_QUARTER_BIT = 1;
	localparam int CDV_EIGHTH_BIT = 2;
	// ------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------
	localparam int CDV_SYNC_DEPTH = 3;
	localparam logic [CDV_SYNC_DEPTH-1:0] CDV_SYNC_RESET = 3'h0;
	localparam logic CDV_GATE_RESET = 1'h0;
	// Phase of the internal clock: low half and high half of one input period
	typedef enum logic [1:0] {
		CDV_PH_LOW = 2'h1,
		CDV_PH_HIGH = 2'h2
	} cdv_phase_t;
endpackage

/* File: src/cdv_sync.sv */
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/100ps
module cdv_sync
	import cdv_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic async_in,
	output logic sync_out
);
	logic [CDV_SYNC_DEPTH-1:0] stage_reg;
	logic [CDV_SYNC_DEPTH-1:0] stage_next;
	logic level_reg;
	logic level_next;

	always_comb begin
		stage_next = {stage_reg[CDV_SYNC_DEPTH-2:0], async_in};
		level_next = level_reg;
		// Only a level that two late stages agree on counts
		if (stage_reg[CDV_SYNC_DEPTH-2] == stage_reg[CDV_SYNC_DEPTH-1]) begin
			level_next = stage_reg[CDV_SYNC_DEPTH-1];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stage_reg <= CDV_SYNC_RESET;
			level_reg <= CDV_GATE_RESET;
		end else if (clk_en) begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign sync_out = level_reg;
endmodule

/* File: src/cdv_divider.sv */
// Top: synchronous clock divider giving /2, /4 and /8 of an input clock
//
// Contract
// - Outputs run at one half, quarter and eighth of input clock rate.
// - All stages advance on the same input edge so shared edges align.
// - Active-low enable is captured by a falling-edge flip-flop.
// - Enable changes reach the dividers only while internal clock is low.
// - Enable low and reset low: dividers advance every rising input edge.
// - Enable high sampled at falling edge: dividers stop, outputs hold.
// - Reset high holds every stage in reset whatever clock and enable do.
// - Open enable, reset or clock inputs read as low.
`timescale 1ns/100ps
module cdv_divider
	import cdv_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic div_clk_in,
	input wire logic enable_n_in,
	input wire logic sync_reset_in,
	output logic half_rate_out,
	output logic quarter_rate_out,
	output logic eighth_rate_out
);
	// ------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------
	// Pins are sampled by core_clk; a floating pin is assumed pulled low
	logic clk_s;
	logic en_n_s;
	logic mr_s;

	cdv_sync u_sync_clk (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(div_clk_in),
		.sync_out(clk_s)
	);
	cdv_sync u_sync_en (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(enable_n_in),
		.sync_out(en_n_s)
	);
	cdv_sync u_sync_mr (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(sync_reset_in),
		.sync_out(mr_s)
	);

	// ------------------------------------------------------------
	// Edge detection and gating
	// ------------------------------------------------------------
	cdv_phase_t phase_reg;
	cdv_phase_t phase_next;
	logic en_cap_n_reg;
	logic en_cap_n_next;
	logic gate_n_reg;
	logic gate_n_next;
	logic [CDV_STAGES-1:0] count_reg;
	logic [CDV_STAGES-1:0] count_next;
	logic rise;
	logic fall;

	always_comb begin
		phase_next = phase_reg;
		rise = 1'b0;
		fall = 1'b0;
		unique case (phase_reg)
			CDV_PH_LOW: begin
				if (clk_s) begin
					phase_next = CDV_PH_HIGH;
					rise = 1'b1;
				end
			end
			CDV_PH_HIGH: begin
				if (!clk_s) begin
					phase_next = CDV_PH_LOW;
					fall = 1'b1;
				end
			end
			default: begin
				phase_next = CDV_PH_LOW;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_reg <= CDV_PH_LOW;
		end else if (clk_en) begin
			phase_reg <= phase_next;
		end
	end

	// ------------------------------------------------------------
	// Enable capture
	// ------------------------------------------------------------
	// Taken at the fall only, so enable setup is referenced to that edge
	always_comb begin
		en_cap_n_next = en_cap_n_reg;
		if (fall) begin
			en_cap_n_next = en_n_s;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			en_cap_n_reg <= CDV_GATE_RESET;
		end else if (clk_en) begin
			en_cap_n_reg <= en_cap_n_next;
		end
	end

	// ------------------------------------------------------------
	// Divider gate
	// ------------------------------------------------------------
	// Applied in the low phase only, so a high phase is never cut short
	always_comb begin
		gate_n_next = gate_n_reg;
		if (phase_reg == CDV_PH_LOW && !rise) begin
			gate_n_next = en_cap_n_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gate_n_reg <= CDV_GATE_RESET;
		end else if (clk_en) begin
			gate_n_reg <= gate_n_next;
		end
	end

	// ------------------------------------------------------------
	// Divider stages
	// ------------------------------------------------------------

	always_comb begin
		count_next = count_reg;
		if (mr_s) begin
			count_next = CDV_COUNT_RESET;
		end else if (rise && !gate_n_reg) begin
			// One shared counter: every stage moves on the same edge
			count_next = count_reg + CDV_COUNT_STEP;
		end
		// Gate high: count held, outputs keep their state
	end

	// Reset wins over a rise seen in the same cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_reg <= CDV_COUNT_RESET;
		end else if (clk_en) begin
			count_reg <= count_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Counter bits are the divided clocks; all come straight from flip-flops
	assign half_rate_out = count_reg[CDV_HALF_BIT];
	assign quarter_rate_out = count_reg[CDV_QUARTER_BIT];
	assign eighth_rate_out = count_reg[CDV_EIGHTH_BIT];
endmodule

/* File: tb/cdv_divider_checker.sv */
// Port-level assertions for the clock divider
`timescale 1ns/100ps
module cdv_divider_checker (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic div_clk_in,
	input wire logic enable_n_in,
	input wire logic sync_reset_in,
	input wire logic half_rate_out,
	input wire logic quarter_rate_out,
	input wire logic eighth_rate_out
);
	wire logic [2:0] cnt = {eighth_rate_out, quarter_rate_out, half_rate_out};
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst || !clk_en);
	property p_inc; $changed(cnt) |-> cnt == $past(cnt) + 3'h1 || cnt == 3'h0; endproperty
	a_inc: assert property (p_inc) else $error("count skipped");
	property p_e; $rose(eighth_rate_out) |-> !half_rate_out && !quarter_rate_out && $past(quarter_rate_out); endproperty
	a_e: assert property (p_e) else $error("edges not aligned");
	property p_mr; sync_reset_in [*6] |-> cnt == 3'h0; endproperty
	a_mr: assert property (p_mr) else $error("master reset ignored");
	property p_rst; $fell(sys_rst) |-> cnt == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not low");
	property p_gap; $changed(cnt) |=> ($stable(cnt) || cnt == 3'h0) [*4]; endproperty
	a_gap: assert property (p_gap) else $error("runt step");
	property p_quiet; (!div_clk_in) [*8] |=> $stable(cnt) || cnt == 3'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("step without edge");
	sequence s_off; (enable_n_in && !sync_reset_in) [*8]; endsequence
	property p_hold; s_off ##1 s_off |=> $stable(cnt); endproperty
	a_hold: assert property (p_hold) else $error("held divider moved");
	property p_run; (!enable_n_in && !sync_reset_in) [*8] ##1 $rose(div_clk_in) |-> ##[2:5] $changed(cnt); endproperty
	a_run: assert property (p_run) else $error("edge not counted");
	cover property ($rose(eighth_rate_out));
	cover property ($fell(sync_reset_in));
	cover property ($rose(enable_n_in));
endmodule
bind cdv_divider cdv_divider_checker u_chk (.core_clk, .sys_rst, .clk_en, .div_clk_in, .enable_n_in,
	.sync_reset_in, .half_rate_out, .quarter_rate_out, .eighth_rate_out);

/* File: tb/cdv_clk_src.sv */
// Clock source model feeding the divider input
`timescale 1ns/100ps
module cdv_clk_src (
	input wire logic core_clk,
	input wire logic run,
	output logic div_clk_in
);
	logic [2:0] ph_reg = 3'h0;
	// Parks low when stopped; four-cycle phases keep the sampler happy
	always_ff @(posedge core_clk) ph_reg <= run ? ph_reg + 3'h1 : 3'h0;
	assign div_clk_in = ph_reg[2];
endmodule

/* File: tb/cdv_divider_tb.sv */
// Testbench for the divide-by-2/4/8 block
`timescale 1ns/100ps
module cdv_divider_tb;
	logic core_clk = 0, sys_rst = 1, run = 0, en_n = 0, mr = 0, clk_en = 1;
	logic dclk, h, q, e;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	initial forever #4 core_clk = ~core_clk;
	cdv_clk_src src (.core_clk(core_clk), .run(run), .div_clk_in(dclk));
	cdv_divider dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .div_clk_in(dclk), .enable_n_in(en_n),
		.sync_reset_in(mr), .half_rate_out(h), .quarter_rate_out(q), .eighth_rate_out(e));
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(logic [2:0] seen, logic [2:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rises(int n);
		run = 1;
		tick(8 * n);
		run = 0;
		tick(8);
	endtask
	task automatic t_count();
		mr = 1;
		tick(8);
		mr = 0;
		rises(5);
		chk({e, q, h}, 3'h5);
		rises(3);
		chk({e, q, h}, 3'h0);
	endtask
	// Clock parked low, so the enable is only taken at the first fall
	task automatic t_hold();
		en_n = 1;
		rises(3);
		chk({e, q, h}, 3'h1);
		en_n = 0;
		rises(2);
		chk({e, q, h}, 3'h2);
	endtask
	task automatic t_reset();
		mr = 1;
		rises(2);
		chk({e, q, h}, 3'h0);
		mr = 0;
		rises(1);
		chk({e, q, h}, 3'h1);
	endtask
	// Core frozen: input edges pass unseen, count moves again once enabled
	task automatic t_freeze();
		clk_en = 0;
		rises(2);
		chk({e, q, h}, 3'h1);
		clk_en = 1;
		rises(1);
		chk({e, q, h}, 3'h2);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		tick(16);
		sys_rst = 0;
		tick(2);
		chk({e, q, h}, 3'h0);
		t_count();
		t_hold();
		t_reset();
		t_freeze();
		test_done();
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 1000) begin
			error_cnt++;
			test_done();
		end
	end
endmodule
